// *** core/tff_pkg.sv ***
// package: constants and carriers of the fault-flag block
package tff_pkg;

	// ==========================================
	// sizes and encodings
	localparam int         CH_COUNT     = 16;
	localparam logic [1:0] SEL_NONE     = 2'h0;
	localparam logic [1:0] SEL_OPEN     = 2'h1;
	localparam logic [1:0] SEL_SHORT    = 2'h2;
	localparam logic [1:0] SEL_LEAK     = 2'h3;
	localparam int         CHAIN_MSB    = 16;
	localparam logic [15:0] ALL_ONES    = 16'hffff;
	localparam logic [15:0] ZERO_WORD   = 16'h0000;

	// ==========================================
	// timing
	localparam int         CLK_PERIOD_PS  = 25000;
	localparam int         STAGGER_PS     = 2000;
	// 2 ns per channel is below one 25 ns cycle: one cycle is the floor
	localparam int         STAGGER_RAW    = STAGGER_PS / CLK_PERIOD_PS;
	localparam int         STAGGER_CYC    = (STAGGER_RAW < 1) ? 1 : STAGGER_RAW;
	localparam logic [3:0] STAGGER_CNT    = 4'(STAGGER_CYC - 1);

	// ==========================================
	// interrupt status bit positions
	localparam int         IRQ_OVERTEMP  = 0;
	localparam int         IRQ_WARN      = 1;
	localparam int         IRQ_REFSHORT  = 2;

	// ==========================================
	// register map (word offsets in bytes)
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_FLAGS     = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT  = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK  = 4'hc;
	localparam logic [1:0] CTRL_RESET    = 2'h1;
	localparam logic [2:0] MASK_RESET    = 3'h0;

	// ==========================================
	// carriers
	typedef struct packed {
		logic [15:0] open_string_result;
		logic [15:0] shorted_led_result;
		logic [15:0] leak_result;
	} tff_diag_t;

	typedef struct packed {
		logic overtemp;
		logic warn;
		logic ref_short;
	} tff_cmp_t;

endpackage : tff_pkg

// *** core/tff_sync.sv ***
// two-flop synchroniser for the comparator levels
`timescale 1ns/1ps
module tff_sync (
	// clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           srst_in,
	// levels
	input  wire tff_pkg::tff_cmp_t raw_in,
	output      tff_pkg::tff_cmp_t sync_out
);
	typedef struct packed {
		tff_pkg::tff_cmp_t meta;
		tff_pkg::tff_cmp_t stable;
	} tff_sync_state_t;

	tff_sync_state_t state;
	tff_sync_state_t next_state;

	always_comb
	begin
		next_state.meta   = raw_in;
		next_state.stable = state.meta;
		if (srst_in)
		begin
			next_state = '0;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		state <= next_state;
	end

	assign sync_out = state.stable;
endmodule : tff_sync

// *** core/tff_fault_flags.sv ***
// fault flags, status word capture and staggered sink turn-on
`timescale 1ns/1ps
module tff_fault_flags (
	// clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              srst_in,
	// comparators, asynchronous
	input  wire tff_pkg::tff_cmp_t cmp_in,
	// latch and blanking, same clock domain
	input  wire logic              latch_strobe_in,
	input  wire logic              output_blank_in,
	input  wire logic [16:0]       shift_chain_in,
	input  wire tff_pkg::tff_diag_t diag_in,
	// register port
	input  wire logic [3:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output      logic [31:0]       reg_rdata_out,
	output      logic              irq_out,
	// outputs
	output      logic [15:0]       sink_output_n_out,
	output      logic [15:0]       onoff_latch_out,
	output      logic              chain_load_out,
	output      logic [15:0]       chain_low_out,
	output      logic              overtemp_error_flag_out,
	output      logic              early_heat_warning_out,
	output      logic              ref_pin_short_flag_out
);
	// ==========================================
	// state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RAMP = 2'b10
	} tff_ramp_t;

	typedef struct packed {
		logic        latch_d;
		logic        blank_d;
		logic        ot_flag;
		logic        warn_flag;
		logic        isf_flag;
		logic [1:0]  select;
		logic [15:0] onoff;
		logic [15:0] enabled;
		logic [3:0]  ch;
		logic [3:0]  tick;
		tff_ramp_t   ramp;
		logic [15:0] sinks;
		logic        load;
		logic [15:0] chain_low;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        irq;
		logic [31:0] rdata;
	} tff_state_t;

	tff_state_t        state;
	tff_state_t        next_state;
	tff_pkg::tff_cmp_t cmp_sync;

	// ==========================================
	// comparator synchroniser
	tff_sync u_sync (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.raw_in     (cmp_in),
		.sync_out   (cmp_sync)
	);

	// status word for one select code
	function automatic logic [15:0] status_pick(
		input logic [1:0]         sel,
		input tff_pkg::tff_diag_t diag,
		input logic               ot,
		input logic               warn,
		input logic               ref_pin_short_flag
	);
		logic [15:0] word;
		word = tff_pkg::ZERO_WORD;
		unique case (sel)
			tff_pkg::SEL_OPEN:  word = ot   ? tff_pkg::ALL_ONES : diag.open_string_result;
			tff_pkg::SEL_SHORT: word = warn ? tff_pkg::ALL_ONES : diag.shorted_led_result;
			tff_pkg::SEL_LEAK:  word = ref_pin_short_flag  ? tff_pkg::ALL_ONES : diag.leak_result;
			tff_pkg::SEL_NONE:  word = tff_pkg::ZERO_WORD;
		endcase
		return word;
	endfunction : status_pick

	// ==========================================
	// next state
	logic        latch_rise;
	logic        blank_fall;
	logic        force_off;
	logic [15:0] target;
	logic [15:0] word;
	logic [2:0]  events;

	always_comb
	begin
		next_state = state;
		latch_rise = latch_strobe_in && !state.latch_d;
		blank_fall = !output_blank_in && state.blank_d;
		next_state.latch_d = latch_strobe_in;
		next_state.blank_d = output_blank_in;
		next_state.load    = 1'b0;

		// flags: over-temperature and warning set while the condition lasts, re-evaluated at the latch edge; ref short follows its comparator
		if (latch_rise)
		begin
			next_state.ot_flag   = cmp_sync.overtemp;
			next_state.warn_flag = cmp_sync.warn;
		end
		if (cmp_sync.overtemp)
		begin
			next_state.ot_flag = 1'b1;
		end
		if (cmp_sync.warn)
		begin
			next_state.warn_flag = 1'b1;
		end
		next_state.isf_flag = cmp_sync.ref_short;

		// latch edge: copy chain into on/off latch, then overwrite low bits if chain bit 16 is clear
		word = status_pick(state.select, diag_in, state.ot_flag | cmp_sync.overtemp,
			state.warn_flag | cmp_sync.warn, cmp_sync.ref_short);
		if (latch_rise)
		begin
			next_state.onoff = shift_chain_in[15:0];
			if (!shift_chain_in[tff_pkg::CHAIN_MSB])
			begin
				next_state.load      = 1'b1;
				next_state.chain_low = word;
			end
		end

		// sinks: forced off by shutdown or short, not by the warning
		force_off = cmp_sync.overtemp || cmp_sync.ref_short;
		target    = (force_off || output_blank_in) ? tff_pkg::ZERO_WORD : next_state.onoff;
		if ((blank_fall || (latch_rise && !output_blank_in)) && !force_off)
		begin
			next_state.enabled = tff_pkg::ZERO_WORD;
			next_state.ch      = 4'h0;
			next_state.tick    = tff_pkg::STAGGER_CNT;
			next_state.ramp    = ST_RAMP;
		end
		unique case (state.ramp)
			ST_IDLE:
			begin
				if (next_state.ramp == ST_IDLE)
				begin
					next_state.enabled = 16'hffff;
				end
			end
			ST_RAMP:
			begin
				if (next_state.ch == 4'h0 && next_state.tick == tff_pkg::STAGGER_CNT
					&& next_state.enabled == tff_pkg::ZERO_WORD && state.ch != 4'h0)
				begin
					next_state.ramp = ST_RAMP;
				end
				else if (state.tick != 4'h0)
				begin
					next_state.tick = state.tick - 4'h1;
				end
				else
				begin
					next_state.enabled[state.ch] = 1'b1;
					next_state.tick = tff_pkg::STAGGER_CNT;
					next_state.ch   = state.ch + 4'h1;
					if (state.ch == 4'hf)
					begin
						next_state.ramp = ST_IDLE;
					end
				end
			end
			default:
			begin
				next_state.ramp = ST_IDLE;
			end
		endcase
		next_state.sinks = target & next_state.enabled;

		// registers: read clears status, set wins over clear
		events = {cmp_sync.ref_short, cmp_sync.warn, cmp_sync.overtemp};
		next_state.rdata = 32'h0000_0000;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				tff_pkg::REG_CTRL:     next_state.rdata = {30'h0, state.select};
				tff_pkg::REG_FLAGS:    next_state.rdata = {29'h0, state.isf_flag,
					state.warn_flag, state.ot_flag};
				tff_pkg::REG_IRQ_STAT: next_state.rdata = {29'h0, state.irq_stat};
				tff_pkg::REG_IRQ_MASK: next_state.rdata = {29'h0, state.irq_mask};
				default:               next_state.rdata = 32'h0000_0000;
			endcase
			if (reg_addr_in == tff_pkg::REG_IRQ_STAT)
			begin
				next_state.irq_stat = 3'h0;
			end
		end
		next_state.irq_stat = next_state.irq_stat | events;
		if (reg_wr_in)
		begin
			if (reg_addr_in == tff_pkg::REG_CTRL)
			begin
				next_state.select = reg_wdata_in[1:0];
			end
			if (reg_addr_in == tff_pkg::REG_IRQ_MASK)
			begin
				next_state.irq_mask = reg_wdata_in[2:0];
			end
		end
		next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

		if (srst_in)
		begin
			next_state          = '0;
			next_state.select   = tff_pkg::CTRL_RESET;
			next_state.irq_mask = tff_pkg::MASK_RESET;
			next_state.ramp     = ST_IDLE;
			next_state.enabled  = 16'hffff;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		state <= next_state;
	end

	// ==========================================
	// outputs
	assign sink_output_n_out       = state.sinks;
	assign onoff_latch_out         = state.onoff;
	assign chain_load_out          = state.load;
	assign chain_low_out           = state.chain_low;
	assign overtemp_error_flag_out = state.ot_flag;
	assign early_heat_warning_out  = state.warn_flag;
	assign ref_pin_short_flag_out  = state.isf_flag;
	assign reg_rdata_out           = state.rdata;
	assign irq_out                 = state.irq;
endmodule : tff_fault_flags

// *** test/tff_monitor.sv ***
// checker of flag, latch and register port timing
`timescale 1ns/1ps
module tff_monitor (
	// clock and reset
	input wire logic              sys_clk_in,
	input wire logic              srst_in,
	// watched ports
	input wire tff_pkg::tff_cmp_t cmp_in,
	input wire logic              latch_strobe_in,
	input wire logic [16:0]       shift_chain_in,
	input wire logic              reg_rd_in,
	input wire logic [31:0]       reg_rdata_out,
	input wire logic [15:0]       sink_output_n_out,
	input wire logic [15:0]       onoff_latch_out,
	input wire logic              chain_load_out,
	input wire logic              overtemp_error_flag_out,
	input wire logic              early_heat_warning_out,
	input wire logic              ref_pin_short_flag_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// cycles since reset, so three-deep history is clean
	logic [1:0] up;
	always_ff @(posedge sys_clk_in)
		up <= srst_in ? 2'h0 : ((up == 2'h3) ? up : up + 2'h1);
	a_ot_sinks_off: assert property (up == 2'h3 && $past(cmp_in.overtemp, 3) |->
		sink_output_n_out == 16'h0000) else $error("sinks on in over-temperature");
	a_ot_flag_set: assert property (up == 2'h3 && $past(cmp_in.overtemp, 3) |->
		overtemp_error_flag_out) else $error("over-temperature flag not set");
	a_ot_flag_hold: assert property ($fell(overtemp_error_flag_out) |->
		$past(latch_strobe_in) || $past(latch_strobe_in, 2)) else $error("error flag dropped");
	a_warn_flag_set: assert property (up == 2'h3 && $past(cmp_in.warn, 3) |->
		early_heat_warning_out) else $error("warning flag not set");
	a_warn_flag_hold: assert property ($fell(early_heat_warning_out) |->
		$past(latch_strobe_in) || $past(latch_strobe_in, 2)) else $error("warning dropped");
	a_ref_follows: assert property (up == 2'h3 |->
		ref_pin_short_flag_out == $past(cmp_in.ref_short, 3)) else $error("ref flag late");
	a_ref_sinks_off: assert property (ref_pin_short_flag_out |->
		sink_output_n_out == 16'h0000) else $error("sinks on in ref short");
	a_load_msb: assert property ($rose(latch_strobe_in) |=>
		chain_load_out == !$past(shift_chain_in[16])) else $error("load pulse wrong");
	a_onoff_copy: assert property ($rose(latch_strobe_in) |=>
		onoff_latch_out == $past(shift_chain_in[15:0])) else $error("on/off not copied");
	a_rdata_idle: assert property (!$past(reg_rd_in) |->
		reg_rdata_out == 32'h0) else $error("read data outside read cycle");
endmodule : tff_monitor

bind tff_fault_flags tff_monitor tff_monitor_i (.sys_clk_in, .srst_in, .cmp_in,
	.latch_strobe_in, .shift_chain_in, .reg_rd_in, .reg_rdata_out, .sink_output_n_out,
	.onoff_latch_out, .chain_load_out, .overtemp_error_flag_out, .early_heat_warning_out,
	.ref_pin_short_flag_out);

// *** test/tff_host_model.sv ***
// host side: latch strobe, chain contents and status capture
`timescale 1ns/1ps
module tff_host_model (
	// clock
	input  wire logic        sys_clk_in,
	// requests
	input  wire logic        go_in,
	input  wire logic [16:0] word_in,
	// from the device
	input  wire logic        load_in,
	input  wire logic [15:0] low_in,
	// to the device and bench
	output      logic        latch_strobe_out = 1'b0,
	output      logic [16:0] shift_chain_out = 17'h00000,
	output      logic [15:0] status_out = 16'h0000
);
	always @(posedge sys_clk_in)
	begin
		latch_strobe_out <= go_in;
		if (go_in)
			shift_chain_out <= word_in;
		if (load_in)
			status_out <= low_in;
	end
endmodule : tff_host_model

// *** test/testbench.sv ***
// self-checking bench of the fault-flag block
`timescale 1ns/1ps
module testbench;
	logic               sys_clk_in = 0;
	logic               srst_in = 1;
	tff_pkg::tff_cmp_t  cmp_in = '0;
	tff_pkg::tff_cmp_t  c;
	tff_pkg::tff_diag_t diag_in = '0;
	logic               output_blank_in = 0;
	logic [3:0]         reg_addr_in = 0;
	logic [31:0]        reg_wdata_in = 0;
	logic               reg_wr_in = 0;
	logic               reg_rd_in = 0;
	logic               go = 0;
	logic [16:0]        word = 0;
	logic [16:0]        chain;
	logic [31:0]        rdata;
	logic [31:0]        m;
	logic [15:0]        sink, onoff, low, stat, d, e;
	logic               load, irq, ot, warn, ref_pin_short_flag, lat;
	int                 n_errors = 0;
	int                 compares = 0;
	always #12.5 sys_clk_in = ~sys_clk_in;
	tff_fault_flags tff_fault_flags_i (.sys_clk_in, .srst_in, .cmp_in, .latch_strobe_in(lat),
		.output_blank_in, .shift_chain_in(chain), .diag_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out(rdata), .irq_out(irq), .sink_output_n_out(sink),
		.onoff_latch_out(onoff), .chain_load_out(load), .chain_low_out(low),
		.overtemp_error_flag_out(ot), .early_heat_warning_out(warn), .ref_pin_short_flag_out(ref_pin_short_flag));
	tff_host_model tff_host_model_i (.sys_clk_in, .go_in(go), .word_in(word), .load_in(load),
		.low_in(low), .latch_strobe_out(lat), .shift_chain_out(chain), .status_out(stat));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : tick
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge sys_clk_in);
		reg_wr_in <= 0;
		reg_rd_in <= 0;
		#1 if (!w) check("rdata", rdata, v);
	endtask : bus
	task automatic latch(input logic [16:0] w);
		@(posedge sys_clk_in);
		go <= 1;
		word <= w;
		@(posedge sys_clk_in);
		go <= 0;
		tick(4);
		#1;
	endtask : latch
	function automatic logic [15:0] sw(input int s, input tff_pkg::tff_cmp_t k);
		case (s)
			1: return k.overtemp ? 16'hffff : diag_in.open_string_result;
			2: return k.warn ? 16'hffff : diag_in.shorted_led_result;
			3: return k.ref_short ? 16'hffff : diag_in.leak_result;
			default: return 16'h0000;
		endcase
	endfunction : sw
	task automatic give_verdict;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		tick(20000);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(5823));
		tick(10);
		srst_in <= 0;
		bus(0, tff_pkg::REG_CTRL, 32'h1);
		bus(0, 4'h2, 32'h0);
		bus(1, tff_pkg::REG_IRQ_MASK, 32'h1);
		latch(17'h0ffff);
		check("ramp", 32'({sink[15], sink[0]}), 32'h1);
		tick(20);
		output_blank_in <= 1;
		tick(3);
		output_blank_in <= 0;
		tick(4);
		#1 check("blank", 32'({sink[15], sink[0]}), 32'h1);
		for (int f = 0; f < 4; f++)
		begin
			c = f ? 3'h4 >> (f - 1) : 3'h0;
			m = f ? 32'h1 << (f - 1) : 32'h0;
			cmp_in <= c;
			for (int s = 0; s < 4; s++)
			begin
				bus(1, tff_pkg::REG_CTRL, 32'(s));
				diag_in <= {$urandom, 16'($urandom)};
				d = 16'($urandom);
				latch({1'b0, d});
				tick(20);
				e = sw(s, c);
				check("status", 32'(stat), 32'(e));
				check("sinks", 32'(sink), 32'((c.overtemp | c.ref_short) ? 16'h0 : d));
			end
			bus(0, tff_pkg::REG_FLAGS, m);
			// host backs off power here, clearing every comparator input
			cmp_in <= '0;
			tick(6);
			check("hold", 32'({ref_pin_short_flag, warn, ot}), m & 32'h3);
			check("irq", 32'(irq), 32'(f == 1));
			bus(0, tff_pkg::REG_IRQ_STAT, m);
			latch({1'b1, d});
			tick(20);
			check("cleared", 32'({ref_pin_short_flag, warn, ot}), 32'h0);
			check("resume", 32'(sink), 32'(d));
			check("refused", 32'(stat), 32'(e));
			check("irq", 32'(irq), 32'h0);
		end
		give_verdict();
	end
endmodule : testbench
